// ===== core/twi_target.sv
// Two-wire target: address match, data register, clock stretch
//
// Decided for this implementation: strobed register access.
`include "twi_target_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module twi_target (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic target_irq_req,
  output logic [7:0] target_irq_vector
);

  // ----------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------
  logic [1:0] pin_in;
  logic [1:0] lvl_r;
  logic [1:0] lvl_d_r;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign pin_in = {sda_i, scl_i};

  // Three stages; a level counts once stages two and three agree
  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic [2:0] s_r;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        s_r <= 3'h7;
        lvl_r[g] <= 1'b1;
      end else begin
        s_r <= {s_r[1:0], pin_in[g]};
        if (s_r[1] == s_r[2]) begin
          lvl_r[g] <= s_r[2];
        end
      end
    end
  end

  // Previous filtered levels for edge finding
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lvl_d_r <= 2'h3;
    end else begin
      lvl_d_r <= lvl_r;
    end
  end

  // SDA moving while SCL stays high marks start or stop
  assign scl_rise = lvl_r[0] & ~lvl_d_r[0];
  assign scl_fall = ~lvl_r[0] & lvl_d_r[0];
  assign bus_start = lvl_r[0] & lvl_d_r[0] & lvl_d_r[1] & ~lvl_r[1];
  assign bus_stop = lvl_r[0] & lvl_d_r[0] & ~lvl_d_r[1] & lvl_r[1];

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic [7:0] ctrl_a_r;
  logic ack_choice_r;
  logic [7:0] own_addr_r;
  logic [7:0] mask_r;
  logic [7:0] data_r;
  logic dif_r;
  logic addr_stop_irq_flag_r;
  logic ap_r;
  logic dir_r;
  logic rxack_r;
  logic coll_r;
  logic berr_r;
  logic hold;
  logic wr_ca;
  logic wr_cb;
  logic wr_st;
  logic wr_ad;
  logic wr_mk;
  logic data_wr;
  logic data_rd;
  logic [1:0] cmd;
  logic cmd_done;
  logic go;
  logic ack_now;
  logic ack_drive;

  assign wr_ca = reg_wr & (reg_addr == `TWI_TGT_BASE + `TGT_TARGET_CONTROL_A);
  assign wr_cb = reg_wr & (reg_addr == `TWI_TGT_BASE + `TGT_TARGET_CONTROL_B);
  assign wr_st = reg_wr & (reg_addr == `TWI_TGT_BASE + `TGT_STATUS);
  assign wr_ad = reg_wr & (reg_addr == `TWI_TGT_BASE + `TGT_ADDR);
  assign wr_mk = reg_wr & (reg_addr == `TWI_TGT_BASE + `TGT_MASK);

  // clock held while the data flag, or the address flag with ap_r set, is pending
  assign hold = dif_r | (addr_stop_irq_flag_r & ap_r);

  assign data_wr = hold & reg_wr
    & (reg_addr == `TWI_TGT_BASE + `TGT_DATA);
  assign data_rd = hold & reg_rd
    & (reg_addr == `TWI_TGT_BASE + `TGT_DATA);

  assign cmd = reg_wdata[`CB_CMD_HI:`CB_CMD_LO];
  assign cmd_done = hold & wr_cb & (cmd == `CMD_COMPLETE);
  // any data access releases the clock
  assign go = cmd_done | data_wr | data_rd
    | (hold & wr_cb & (cmd == `CMD_RESPONSE));

  // Ack bit written with a command takes effect first
  assign ack_now = wr_cb ? reg_wdata[`CB_ACK] : ack_choice_r;

  // plain reads release SDA; smart reads send the ack choice
  // ack choice 0 pulls SDA low
  assign ack_drive = (data_rd & ~ctrl_a_r[`CA_AUTO_ACK_ON_READ_EN]) ? 1'b0 : ~ack_now;

  // Control registers, written by software only
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_a_r <= `RST_REG;
      ack_choice_r <= 1'b0;
      own_addr_r <= `RST_REG;
      mask_r <= `RST_REG;
    end else begin
      if (wr_ca) begin
        ctrl_a_r <= reg_wdata;
      end
      if (wr_cb) begin
        ack_choice_r <= reg_wdata[`CB_ACK];
      end
      if (wr_ad) begin
        own_addr_r <= reg_wdata;
      end
      if (wr_mk) begin
        mask_r <= reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // Address match
  // ----------------------------------------
  twi_target_pkg::link_state_t state_r;
  twi_target_pkg::link_state_t state_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic sda_oe_nxt;
  logic ack_end_r;
  logic ack_end_nxt;
  logic hit;
  logic [6:0] rx_addr;

  // a 11110nn first byte matches like any seven-bit address
  assign rx_addr = sh_r[7:1];

  always_comb begin
    hit = 1'b0;
    if (!mask_r[0]) begin
      hit = ((rx_addr ^ own_addr_r[7:1]) & ~mask_r[7:1]) == 7'h00;
    end else begin
      hit = (rx_addr == own_addr_r[7:1]) | (rx_addr == mask_r[7:1]);
    end
    if (own_addr_r[0] && rx_addr == `GC_ADDR) begin
      hit = 1'b1;
    end
    if (ctrl_a_r[`CA_ACCEPT_ALL_ADDRESSES_EN]) begin
      hit = 1'b1;
    end
  end

  // ----------------------------------------
  // Link sequencer
  // ----------------------------------------
  logic ev_match;
  logic ev_rx;
  logic ev_txhold;
  logic ev_stop;
  logic ev_rxack;
  logic ev_coll;
  logic ev_berr;
  logic shifting;

  assign shifting = (state_r == twi_target_pkg::S_ADDR)
    | (state_r == twi_target_pkg::S_RX)
    | (state_r == twi_target_pkg::S_TX);

  // Next state and events of the byte engine
  always_comb begin
    state_nxt = state_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    sda_oe_nxt = sda_oe;
    ack_end_nxt = ack_end_r;
    ev_match = 1'b0;
    ev_rx = 1'b0;
    ev_txhold = 1'b0;
    ev_stop = 1'b0;
    ev_rxack = 1'b0;
    ev_coll = 1'b0;
    ev_berr = (bus_start | bus_stop) & shifting & (cnt_r != 4'h0);
    if (!ctrl_a_r[`CA_ENABLE]) begin
      state_nxt = twi_target_pkg::S_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (bus_stop) begin
      // Any stop counts, so one after our NACK still reaches software
      ev_stop = 1'b1;
      state_nxt = twi_target_pkg::S_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (bus_start) begin
      state_nxt = twi_target_pkg::S_ADDR;
      cnt_nxt = 4'h0;
      sda_oe_nxt = 1'b0;
    end else begin
      case (state_r)
        twi_target_pkg::S_ADDR, twi_target_pkg::S_RX: begin
          if (scl_rise && cnt_r != 4'h8) begin
            sh_nxt = {sh_r[6:0], lvl_r[1]};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            if (state_r == twi_target_pkg::S_RX) begin
              // ten-bit second byte also lands here
              ev_rx = 1'b1;
              state_nxt = twi_target_pkg::S_HOLD_R;
            end else if (hit) begin
              ev_match = 1'b1;
              state_nxt = twi_target_pkg::S_HOLD_A;
            end else begin
              state_nxt = twi_target_pkg::S_IDLE;
            end
          end
        end
        twi_target_pkg::S_HOLD_A, twi_target_pkg::S_HOLD_R: begin
          if (go) begin
            if (cmd_done && dir_r
                && state_r == twi_target_pkg::S_HOLD_A) begin
              state_nxt = twi_target_pkg::S_IDLE;
            end else begin
              state_nxt = twi_target_pkg::S_ACK;
              sda_oe_nxt = ack_drive;
              ack_end_nxt = cmd_done;
            end
          end
        end
        twi_target_pkg::S_ACK: begin
          if (scl_fall) begin
            sda_oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            if (ack_end_r || !sda_oe) begin
              state_nxt = twi_target_pkg::S_IDLE;
            end else if (dir_r) begin
              // Master read: wait for the byte to send
              ev_txhold = 1'b1;
              state_nxt = twi_target_pkg::S_TX_ACK;
            end else begin
              state_nxt = twi_target_pkg::S_RX;
            end
          end
        end
        twi_target_pkg::S_TX: begin
          if (scl_rise && !sda_oe && !lvl_r[1]) begin
            // A high bit lost to another driver stops our output
            ev_coll = 1'b1;
            state_nxt = twi_target_pkg::S_IDLE;
          end else if (scl_fall) begin
            if (cnt_r == 4'h7) begin
              sda_oe_nxt = 1'b0;
              state_nxt = twi_target_pkg::S_TX_ACK;
              cnt_nxt = 4'h8;
            end else begin
              cnt_nxt = cnt_r + 4'h1;
              sh_nxt = {sh_r[6:0], 1'b0};
              sda_oe_nxt = ~sh_r[6];
            end
          end
        end
        twi_target_pkg::S_TX_ACK: begin
          // take master ack, then hold for next byte on ACK, go idle on NACK
          if (cnt_r == 4'h8 && scl_rise) begin
            ev_rxack = 1'b1;
            cnt_nxt = 4'h9;
          end else if (cnt_r == 4'h9 && scl_fall) begin
            if (!rxack_r) begin
              ev_txhold = 1'b1;
            end else begin
              state_nxt = twi_target_pkg::S_IDLE;
            end
          end else if (go) begin
            if (cmd_done) begin
              state_nxt = twi_target_pkg::S_IDLE;
            end else begin
              // software byte goes out MSB first
              sh_nxt = data_wr ? reg_wdata : data_r;
              sda_oe_nxt = data_wr ? ~reg_wdata[7] : ~data_r[7];
              cnt_nxt = 4'h0;
              state_nxt = twi_target_pkg::S_TX;
            end
          end
        end
        default: begin
          state_nxt = twi_target_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= twi_target_pkg::S_IDLE;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      sda_oe <= 1'b0;
      ack_end_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      sda_oe <= sda_oe_nxt;
      ack_end_r <= ack_end_nxt;
    end
  end

  // ----------------------------------------
  // Status flags and data register
  // ----------------------------------------
  logic dif_nxt;
  logic addr_stop_irq_flag_nxt;
  logic ap_nxt;
  logic stop_flag;

  // stop raises the flag only when enabled
  assign stop_flag = ev_stop & ctrl_a_r[`CA_STOP_IRQ_EN];

  // Hardware set wins over any clear in the same cycle
  always_comb begin
    // flags cleared by data access or command
    dif_nxt = dif_r & ~go & ~(wr_st & reg_wdata[`ST_DIF]);
    addr_stop_irq_flag_nxt = addr_stop_irq_flag_r & ~go & ~(wr_st & reg_wdata[`ST_ADDR_STOP_IRQ_FLAG]);
    ap_nxt = wr_st ? reg_wdata[`ST_AP] : ap_r;
    dif_nxt = dif_nxt | ev_rx | ev_txhold;
    addr_stop_irq_flag_nxt = addr_stop_irq_flag_nxt | ev_match | stop_flag;
    // cause bit follows the last setter
    if (ev_match) begin
      ap_nxt = 1'b1;
    end else if (stop_flag) begin
      ap_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dif_r <= 1'b0;
      addr_stop_irq_flag_r <= 1'b0;
      ap_r <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      dif_r <= dif_nxt;
      addr_stop_irq_flag_r <= addr_stop_irq_flag_nxt;
      ap_r <= ap_nxt;
      // stretch SCL from the flags' next values
      scl_oe <= dif_nxt | (addr_stop_irq_flag_nxt & ap_nxt);
    end
  end

  // Direction, ack, error flags
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_r <= 1'b0;
      rxack_r <= 1'b0;
      coll_r <= 1'b0;
      berr_r <= 1'b0;
    end else begin
      if (ev_match) begin
        dir_r <= sh_r[0];
      end else if (wr_st) begin
        dir_r <= reg_wdata[`ST_DIR];
      end
      if (ev_rxack) begin
        rxack_r <= lvl_r[1];
      end
      coll_r <= ev_coll | (coll_r & ~bus_start
        & ~(wr_st & reg_wdata[`ST_COLL]));
      berr_r <= ev_berr | (berr_r & ~(wr_st & reg_wdata[`ST_BERR]));
    end
  end

  // Data register: software byte or received byte
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_r <= 8'h00;
    end else if (ev_match || ev_rx) begin
      data_r <= sh_r;
    end else if (data_wr) begin
      data_r <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Read port and fixed outputs
  // ----------------------------------------
  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `TWI_TGT_BASE + `TGT_TARGET_CONTROL_A: reg_rdata <= ctrl_a_r;
        `TWI_TGT_BASE + `TGT_TARGET_CONTROL_B: begin
          reg_rdata <= {5'h00, ack_choice_r, 2'h0};
        end
        `TWI_TGT_BASE + `TGT_STATUS: begin
          reg_rdata <= {dif_r, addr_stop_irq_flag_r, hold, rxack_r,
            coll_r, berr_r, dir_r, ap_r};
        end
        `TWI_TGT_BASE + `TGT_ADDR: reg_rdata <= own_addr_r;
        `TWI_TGT_BASE + `TGT_DATA: reg_rdata <= data_r;
        `TWI_TGT_BASE + `TGT_MASK: reg_rdata <= mask_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      target_irq_req <= 1'b0;
      target_irq_vector <= `VEC_TARGET;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      target_irq_req <= (ctrl_a_r[`CA_LVL_HI:`CA_LVL_LO] != 2'h0)
        & ((dif_r & ctrl_a_r[`CA_DIEN])
        | (addr_stop_irq_flag_r & ctrl_a_r[`CA_APIEN]));
      target_irq_vector <= `VEC_TARGET;
    end
  end

endmodule : twi_target

`default_nettype wire

// ===== core/twi_target_cfg.svh
// Offsets, field positions and reset values of the two-wire target
`ifndef TWI_TARGET_CFG_SVH
`define TWI_TARGET_CFG_SVH

// Module map on the register port
`define TWI_CTRL_OFS 4'h0
`define TWI_MASTER_BASE 4'h1
`define TWI_TGT_BASE 4'h8

// Target register offsets within its group
`define TGT_TARGET_CONTROL_A 4'h0
`define TGT_TARGET_CONTROL_B 4'h1
`define TGT_STATUS 4'h2
`define TGT_ADDR 4'h3
`define TGT_DATA 4'h4
`define TGT_MASK 4'h5

// Control A fields
`define CA_LVL_HI 7
`define CA_LVL_LO 6
`define CA_DIEN 5
`define CA_APIEN 4
`define CA_ENABLE 3
`define CA_STOP_IRQ_EN 2
`define CA_ACCEPT_ALL_ADDRESSES_EN 1
`define CA_AUTO_ACK_ON_READ_EN 0

// Control B fields
`define CB_ACK 2
`define CB_CMD_HI 1
`define CB_CMD_LO 0

// Status fields
`define ST_DIF 7
`define ST_ADDR_STOP_IRQ_FLAG 6
`define ST_HOLD 5
`define ST_RXACK 4
`define ST_COLL 3
`define ST_BERR 2
`define ST_DIR 1
`define ST_AP 0

// Commands
`define CMD_COMPLETE 2'h2
`define CMD_RESPONSE 2'h3

// Interrupt vector word offsets
`define VEC_TARGET 8'h00
`define VEC_MASTER 8'h02

// Reset value and general-call address
`define RST_REG 8'h00
`define GC_ADDR 7'h00

`endif

// ===== core/twi_target_pkg.sv
// Types of the two-wire target
package twi_target_pkg;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_HOLD_A = 3'b010,
    S_ACK = 3'b011,
    S_RX = 3'b100,
    S_HOLD_R = 3'b101,
    S_TX = 3'b110,
    S_TX_ACK = 3'b111
  } link_state_t;

endpackage : twi_target_pkg

// ===== verif/twi_target_properties.sv
// Port-level assertions of the two-wire target, bound to its top
`timescale 1ns/10ps
`default_nettype none
module twi_target_properties (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic target_irq_req,
  input wire logic [7:0] target_irq_vector
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ------
  // Software steps that end a clock stretch
  // ------
  sequence data_go;
    (reg_rd || reg_wr) && reg_addr == 4'hC && scl_oe;
  endsequence
  sequence cmd_go;
    reg_wr && reg_addr == 4'h9 && reg_wdata[1] && scl_oe;
  endsequence
  a_data_release: assert property (data_go |-> ##[1:2] !scl_oe)
    else $error("clock still held after data access");
  a_cmd_release: assert property (cmd_go |-> ##[1:2] !scl_oe)
    else $error("clock still held after command");
  a_hold_until_go: assert property (
    scl_oe && !reg_wr && !reg_rd |=> scl_oe)
    else $error("clock released without software");
  // Stretch and data changes only while the clock wire is low
  a_hold_in_low: assert property ($rose(scl_oe) |-> !scl_i)
    else $error("stretch begun with clock high");
  a_sda_in_low: assert property ($changed(sda_oe) |-> !$past(scl_i))
    else $error("data line changed with clock high");
  a_unmapped_zero: assert property (
    reg_rd && (reg_addr < 4'h8 || reg_addr > 4'hD) |=> reg_rdata == 8'h00)
    else $error("outside target group read nonzero");
  a_vector_fixed: assert property (target_irq_vector == 8'h00)
    else $error("target vector offset wrong");
  a_hold_flag_read: assert property (
    reg_rd && reg_addr == 4'hA && scl_oe && $past(scl_oe)
    |=> reg_rdata[5] && (reg_rdata[7] || reg_rdata[6]))
    else $error("hold flag not shown during stretch");
endmodule : twi_target_properties

bind twi_target twi_target_properties chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .target_irq_req(target_irq_req), .target_irq_vector(target_irq_vector)
);
`default_nettype wire

// ===== verif/twi_bus_master.sv
// Behavioural two-wire bus master facing the target
`timescale 1ns/10ps
`default_nettype none
module twi_bus_master (
  input wire logic scl,
  input wire logic sda,
  output var logic scl_low,
  output var logic sda_low
);
  // ------
  // Bit and byte cycles
  // ------
  // Both lines released: pull-ups take them high
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Long low phase before slots where the target may stretch first
  task automatic clk_bit(input logic b, input int lo, output logic s);
    #80;
    sda_low = ~b;
    #(lo);
    scl_low = 1'b0;
    for (int i = 0; i < 20000 && scl !== 1'b1; i++) #40;
    #60;
    s = sda;
    #60;
    scl_low = 1'b1;
  endtask : clk_bit
  task automatic start;
    // Odd offset keeps every wire change off the target's clock edges
    #7;
    sda_low = 1'b1;
    #160;
    scl_low = 1'b1;
  endtask : start
  task automatic stop;
    #80;
    sda_low = 1'b1;
    #120;
    scl_low = 1'b0;
    #160;
    sda_low = 1'b0;
    #320;
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], 120, s);
    clk_bit(1'b1, 400, ack);
  endtask : wr_byte
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, 400, d[i]);
    clk_bit(ack, 400, s);
  endtask : rd_byte
endmodule : twi_bus_master
`default_nettype wire

// ===== verif/two_wire_target_address_data_bench.sv
// Self-checking bench of the two-wire target
`timescale 1ns/10ps
`default_nettype none
module two_wire_target_address_data_bench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic scl_o;
  logic scl_oe;
  logic sda_o;
  logic sda_oe;
  logic m_scl_low;
  logic m_sda_low;
  logic target_irq_req;
  logic [7:0] target_irq_vector;
  wire scl_w = ~((scl_oe & ~scl_o) | m_scl_low);
  wire sda_w = ~((sda_oe & ~sda_o) | m_sda_low);
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 11134;
  int cycles = 0;
  logic [15:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] rv;
  logic [6:0] a7;
  logic [6:0] b7;
  logic [7:0] d;
  logic [7:0] e;
  logic [2:0] k;
  // ------
  // Clock, design and far side
  // ------
  always #20 ref_clk = ~ref_clk;
  twi_target DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .target_irq_req(target_irq_req),
    .target_irq_vector(target_irq_vector)
  );
  twi_bus_master bm (
    .scl(scl_w), .sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low)
  );
  // ------
  // Tasks
  // ------
  task automatic finish_test;
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // Note is mask over expected value; a zero mask only consumes
  task automatic cmp8(input logic [15:0] ex, input logic [7:0] got);
    if (ex[15:8] != 8'h00) begin
      cmp_count++;
      if ((got & ex[15:8]) !== ex[7:0]) begin
        n_mismatch++;
        $display("MISMATCH %0t got %h exp %h", $time, got, ex[7:0]);
      end
    end
  endtask : cmp8
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] m,
                    input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back({m, v});
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  // Polls a status bit; the software side of a stretch
  task automatic wait_st(input int b);
    rv = 8'h00;
    for (int i = 0; i < 400 && rv[b] !== 1'b1; i++) rd(4'hA, 8'h00, 8'h00);
    if (rv[b] !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t status flag never set", $time);
    end
  endtask : wait_st
  // One addressed write; m says whether the target should answer
  task automatic addr_case(input logic [7:0] ca, input logic [7:0] ad,
      input logic [7:0] mk, input logic [7:0] tx, input logic m);
    logic ack;
    wr(4'h8, ca);
    wr(4'hB, ad);
    wr(4'hD, mk);
    fork
      begin
        bm.start();
        bm.wr_byte(tx, ack);
      end
      if (m) begin
        wait_st(6);
        rd(4'hA, 8'hE3, {3'b011, 3'b000, tx[0], 1'b1});
        rd(4'hC, 8'hFF, tx);
      end
    join
    cmp8({8'h01, 7'h00, ~m}, {7'h00, ack});
    bm.stop();
  endtask : addr_case
  // Read results against the oldest note; also the run's watchdog
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (rd_seen && exp_q.size() > 0) cmp8(exp_q.pop_front(), reg_rdata);
    rd_seen <= reg_rd;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // ------
  // Main sequence
  // ------
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 16; i++) rd(4'(i), 8'hFF, 8'h00);
    wr(4'h1, 8'hFF);
    wr(4'hC, 8'h5A);
    rd(4'h1, 8'hFF, 8'h00);
    rd(4'hC, 8'hFF, 8'h00);
    a7 = 7'($random(seed)) | 7'h10;
    b7 = a7 ^ 7'h30;
    addr_case(8'h09, {a7, 1'b0}, 8'h00, {a7, 1'b0}, 1'b1);
    addr_case(8'h09, {a7, 1'b0}, 8'h00, {a7 ^ 7'h01, 1'b0}, 1'b0);
    addr_case(8'h09, {a7, 1'b0}, 8'h00, 8'h00, 1'b0);
    addr_case(8'h09, {a7, 1'b1}, 8'h00, 8'h00, 1'b1);
    addr_case(8'h0B, {a7, 1'b0}, 8'h00, {a7 ^ 7'h2A, 1'b0}, 1'b1);
    addr_case(8'h09, {a7, 1'b0}, 8'h08, {a7, 1'b0} ^ 8'h08, 1'b1);
    addr_case(8'h09, {a7, 1'b0}, 8'h08, {a7, 1'b0} ^ 8'h10, 1'b0);
    addr_case(8'h09, {a7, 1'b0}, {b7, 1'b1}, {b7, 1'b0}, 1'b1);
    addr_case(8'h09, {a7, 1'b0}, {b7, 1'b1}, {a7, 1'b0}, 1'b1);
    // Ten-bit write with stop flag, then a command with NACK
    wr(4'h8, 8'h5D);
    wr(4'hB, 8'hF4);
    wr(4'hD, 8'h00);
    d = 8'($random(seed));
    e = 8'($random(seed));
    fork
      begin
        bm.start();
        bm.wr_byte(8'hF4, k[0]);
        bm.wr_byte(d, k[1]);
        bm.wr_byte(e, k[2]);
        bm.stop();
      end
      begin
        wait_st(6);
        rd(4'hC, 8'hFF, 8'hF4);
        wait_st(7);
        rd(4'hA, 8'hE3, 8'hA1);
        rd(4'hC, 8'hFF, d);
        rd(4'hA, 8'hE0, 8'h00);
        wait_st(7);
        wr(4'h9, 8'h07);
        rd(4'hC, 8'hFF, e);
        wait_st(6);
        rd(4'hA, 8'hE1, 8'h40);
      end
    join
    cmp8({8'h07, 8'h04}, {5'h00, k});
    cmp8({8'h01, 8'h01}, {7'h00, target_irq_req});
    wr(4'hA, 8'h40);
    rd(4'hA, 8'h40, 8'h00);
    cmp8({8'h01, 8'h00}, {7'h00, target_irq_req});
    // Master read of one byte, ended by NACK
    wr(4'h8, 8'h09);
    wr(4'hB, {a7, 1'b0});
    d = 8'($random(seed));
    fork
      begin
        bm.start();
        bm.wr_byte({a7, 1'b1}, k[0]);
        bm.rd_byte(1'b1, e);
        bm.stop();
      end
      begin
        wait_st(6);
        wr(4'h9, 8'h00);
        rd(4'hA, 8'hE3, 8'h63);
        rd(4'hC, 8'hFF, {a7, 1'b1});
        wait_st(7);
        wr(4'hC, d);
      end
    join
    cmp8({8'hFF, d}, e);
    cmp8({8'h01, 8'h00}, {7'h00, k[0]});
    rd(4'hA, 8'h90, 8'h10);
    finish_test();
  end
endmodule : two_wire_target_address_data_bench
`default_nettype wire
